/* File: rtl/rsr_snoop_resp.v */
// Operation
// [R01] ReadOnce: Invalid stays; UniqueClean keeps state, shared
// [R02] ReadOnce passing Dirty must end SharedClean/Invalid
// [R03] ReadOnce hitting Dirty returns line data
// [R04] ReadOnce returns data for any valid copy
// [R05] ReadOnce hands line over Clean, PassDirty low
// [R06] IsShared high whenever a copy is kept
// [R07] Read snoops: Clean lines end SharedClean or Invalid
// [R08] Read snoops: Dirty lines follow permitted transitions
// [R09] Exclusive-sequence line stays valid on read snoops
// [R10] Read snoops return data whenever held
// [R11] ReadClean: keep Dirty, PassDirty low; interconnect writes
// [R12] ReadShared initiator must accept a passed Dirty
// [R13] ReadShared default: pass Dirty, keep SharedClean
// [R14] ReadShared unknown writer: Dirty goes to initiator
// [R15] ReadNotSharedDirty passes Dirty only when invalidating
// [R16] ReadUnique: end Invalid; PassDirty only if Dirty
// [R17] ReadUnique hitting Dirty returns line data
// [R18] ReadUnique hitting Clean also returns data
// [R19] DataTransfer bit marks data on data channel
// [R20] Respond only after snoop address handshake
// [R21] Look up and update line state with response
`include "rsr_consts.vh"
`default_nettype none

module rsr_snoop_resp (
    input  wire                       clk,
    input  wire                       rst_n,
    input  wire                       acvalid,
    output wire                       acready,
    input  wire [`RSR_ADDR_W-1:0]     acaddr,
    input  wire [`RSR_SNP_W-1:0]      acsnoop,
    output wire                       crvalid,
    input  wire                       crready,
    output reg  [`RSR_RESP_W-1:0]     crresp,
    output wire                       cdvalid,
    input  wire                       cdready,
    output reg  [`RSR_DATA_W-1:0]     cddata,
    output wire                       cdlast,
    input  wire                       lw_valid,
    output wire                       lw_ready,
    input  wire [`RSR_ADDR_W-1:0]     lw_addr,
    input  wire [`RSR_ST_W-1:0]       lw_state,
    input  wire [`RSR_LINE_DW-1:0]    lw_data,
    input  wire                       excl_valid,
    input  wire [`RSR_ADDR_W-1:0]     excl_addr,
    input  wire [1:0]                 next_writer,
    input  wire                       init_store_first,
    output wire                       snoop_busy
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_DECIDE = 2'h1;
    localparam [1:0] ST_RESP   = 2'h2;

    function [`RSR_IDX_W-1:0] line_idx;
        input [`RSR_ADDR_W-1:0] a;
        line_idx = a[`RSR_IDX_MSB:`RSR_IDX_LSB];
    endfunction

    function [`RSR_TAG_W-1:0] line_tag;
        input [`RSR_ADDR_W-1:0] a;
        line_tag = a[`RSR_ADDR_W-1:`RSR_TAG_LSB];
    endfunction

    function [`RSR_LINE_W-1:0] line_of;
        input [`RSR_ADDR_W-1:0] a;
        line_of = a[`RSR_ADDR_W-1:`RSR_LINE_LSB];
    endfunction

    // Line store in flip-flops; only the state is reset, tags and data are don't-care
    reg  [`RSR_ST_W-1:0]    lstate_q [0:`RSR_ENTRIES-1];
    reg  [`RSR_TAG_W-1:0]   ltag_q   [0:`RSR_ENTRIES-1];
    reg  [`RSR_LINE_DW-1:0] ldata_q  [0:`RSR_ENTRIES-1];

    reg  [1:0]              fsm_q;
    reg  [1:0]              fsm_d;
    reg  [`RSR_ADDR_W-1:0]  addr_q;
    reg  [`RSR_SNP_W-1:0]   snp_q;
    reg                     cr_pend_q;
    reg                     cd_pend_q;
    reg                     beat_q;
    reg  [`RSR_DATA_W-1:0]  hi_word_q;

    wire [`RSR_IDX_W-1:0]   snp_idx;
    wire                    tag_hit;
    wire [`RSR_ST_W-1:0]    init_state;
    wire                    excl_hit;
    wire                    dec_supported;
    wire [`RSR_ST_W-1:0]    dec_end_state;
    wire                    dec_pass_dirty;
    wire                    dec_is_shared;
    wire                    dec_data_xfer;
    wire                    ac_hs;
    wire                    cr_hs;
    wire                    cd_hs;
    wire                    lw_take;
    wire                    snp_update;
    wire                    cr_done;
    wire                    cd_done;
    reg  [`RSR_RESP_W-1:0]  resp_d;
    integer                 i;

    assign snp_idx    = line_idx(addr_q);
    assign tag_hit    = (ltag_q[snp_idx] == line_tag(addr_q));
    // A tag miss looks exactly like a line held Invalid
    assign init_state = tag_hit ? lstate_q[snp_idx] : `RSR_ST_I; // R21
    assign excl_hit   = excl_valid && (line_of(excl_addr) == line_of(addr_q));

    rsr_decide u_decide (
        .snoop            (snp_q),
        .init_state       (init_state),
        .excl_hit         (excl_hit),
        .next_writer      (next_writer),
        .init_store_first (init_store_first),
        .supported        (dec_supported),
        .end_state        (dec_end_state),
        .pass_dirty       (dec_pass_dirty),
        .is_shared        (dec_is_shared),
        .data_xfer        (dec_data_xfer)
    );

    assign acready    = (fsm_q == ST_IDLE);
    assign ac_hs      = acvalid && acready;
    assign crvalid    = cr_pend_q;
    assign cdvalid    = cd_pend_q;
    assign cdlast     = (beat_q == `RSR_LAST_BEAT);
    assign cr_hs      = crvalid && crready;
    assign cd_hs      = cdvalid && cdready;
    assign snoop_busy = (fsm_q != ST_IDLE);
    // Local fills are held off only in the lookup cycle, so they never race the snoop update
    assign lw_ready   = (fsm_q != ST_DECIDE);
    assign lw_take    = lw_valid && lw_ready;
    // Write back only on a hit: a miss must not overwrite another line's state
    assign snp_update = (fsm_q == ST_DECIDE) && tag_hit && (init_state != `RSR_ST_I);
    assign cr_done    = !cr_pend_q || cr_hs;
    assign cd_done    = !cd_pend_q || (cd_hs && cdlast);

    always @* begin
        resp_d                = `RSR_RESP_NONE;
        resp_d[`RSR_RESP_DT]  = dec_data_xfer; // R19
        resp_d[`RSR_RESP_PD]  = dec_pass_dirty; // R02 R15 R16
        resp_d[`RSR_RESP_IS]  = dec_is_shared; // R06
    end

    always @* begin
        fsm_d = fsm_q;
        case (fsm_q)
            ST_IDLE: begin
                if (ac_hs)
                    fsm_d = ST_DECIDE; // R20
            end
            ST_DECIDE: begin
                fsm_d = ST_RESP;
            end
            ST_RESP: begin
                if (cr_done && cd_done)
                    fsm_d = ST_IDLE;
            end
            default: begin
                fsm_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            fsm_q     <= ST_IDLE;
            addr_q    <= {`RSR_ADDR_W{1'b0}};
            snp_q     <= `RSR_SNP_RONCE;
            cr_pend_q <= 1'b0;
            cd_pend_q <= 1'b0;
            beat_q    <= `RSR_BEAT0;
            crresp    <= `RSR_RESP_NONE;
            cddata    <= {`RSR_DATA_W{1'b0}};
            hi_word_q <= {`RSR_DATA_W{1'b0}};
        end else begin
            fsm_q <= fsm_d;
            if (ac_hs) begin
                addr_q <= acaddr; // R20
                snp_q  <= acsnoop;
            end
            if (fsm_q == ST_DECIDE) begin
                // Response and data launch together with the state update
                crresp    <= resp_d; // R21
                cr_pend_q <= 1'b1; // R20
                cd_pend_q <= dec_data_xfer; // R19
                beat_q    <= `RSR_BEAT0;
                cddata    <= ldata_q[snp_idx][`RSR_DATA_W-1:0];
                hi_word_q <= ldata_q[snp_idx][`RSR_LINE_DW-1:`RSR_DATA_W];
            end else begin
                if (cr_hs)
                    cr_pend_q <= 1'b0;
                if (cd_hs) begin
                    if (cdlast) begin
                        cd_pend_q <= 1'b0;
                    end else begin
                        beat_q <= `RSR_LAST_BEAT;
                        cddata <= hi_word_q;
                    end
                end
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < `RSR_ENTRIES; i = i + 1) begin
                lstate_q[i] <= `RSR_ST_I;
            end
        end else if (snp_update) begin
            lstate_q[snp_idx] <= dec_end_state; // R21
        end else if (lw_take) begin
            lstate_q[line_idx(lw_addr)] <= lw_state;
        end
    end

    always @(posedge clk) begin
        if (lw_take) begin
            ltag_q[line_idx(lw_addr)]  <= line_tag(lw_addr);
            ldata_q[line_idx(lw_addr)] <= lw_data;
        end
    end

endmodule // rsr_snoop_resp

`default_nettype wire

/* File: inc/rsr_consts.vh */
`ifndef RSR_CONSTS_VH
`define RSR_CONSTS_VH

// Five-state line coherence encoding
`define RSR_ST_W          3
`define RSR_ST_I          3'h0
`define RSR_ST_UC         3'h1
`define RSR_ST_UD         3'h2
`define RSR_ST_SC         3'h3
`define RSR_ST_SD         3'h4

// Snoop opcodes on the snoop address channel
`define RSR_SNP_W         4
`define RSR_SNP_RONCE     4'h0
`define RSR_SNP_RSHARED   4'h1
`define RSR_SNP_RCLEAN    4'h2
`define RSR_SNP_RNSD      4'h3
`define RSR_SNP_RUNIQUE   4'h7

// Expected next writer of a line, used by the ReadShared/ReadNotSharedDirty policy
`define RSR_NW_UNKNOWN    2'h0
`define RSR_NW_SNOOPED    2'h1
`define RSR_NW_INIT       2'h2

// Snoop response bit positions
`define RSR_RESP_W        5
`define RSR_RESP_DT       0
`define RSR_RESP_ERR      1
`define RSR_RESP_PD       2
`define RSR_RESP_IS       3
`define RSR_RESP_WU       4
`define RSR_RESP_NONE     5'h00

// Address split: 8-byte lines, 16 direct-mapped entries
`define RSR_ADDR_W        32
`define RSR_IDX_LSB       3
`define RSR_IDX_MSB       6
`define RSR_IDX_W         4
`define RSR_TAG_LSB       7
`define RSR_TAG_W         25
`define RSR_LINE_LSB      3
`define RSR_LINE_W        29
`define RSR_ENTRIES       16

// Line data: two 32-bit beats on the snoop data channel
`define RSR_DATA_W        32
`define RSR_LINE_DW       64
`define RSR_BEAT0         1'b0
`define RSR_LAST_BEAT     1'b1

`endif

/* File: rtl/rsr_decide.v */
`include "rsr_consts.vh"
`default_nettype none

module rsr_decide (
    input  wire [`RSR_SNP_W-1:0] snoop,
    input  wire [`RSR_ST_W-1:0]  init_state,
    input  wire                  excl_hit,
    input  wire [1:0]            next_writer,
    input  wire                  init_store_first,
    output reg                   supported,
    output reg  [`RSR_ST_W-1:0]  end_state,
    output reg                   pass_dirty,
    output reg                   is_shared,
    output reg                   data_xfer
);

    function is_dirty;
        input [`RSR_ST_W-1:0] s;
        is_dirty = (s == `RSR_ST_UD) || (s == `RSR_ST_SD);
    endfunction

    function is_valid;
        input [`RSR_ST_W-1:0] s;
        is_valid = (s != `RSR_ST_I);
    endfunction

    always @* begin
        supported  = 1'b1;
        end_state  = init_state;
        pass_dirty = 1'b0;
        case (snoop)
            // Keep the line as held and hand it over clean; never pass dirty
            `RSR_SNP_RONCE: begin
                end_state = init_state; // R01 R02 R05
            end
            // Dirty stays here so memory is not written back at once
            `RSR_SNP_RCLEAN: begin
                if (is_dirty(init_state))
                    end_state = `RSR_ST_SD; // R08 R11
                else if (is_valid(init_state))
                    end_state = `RSR_ST_SC; // R07 R09
            end
            `RSR_SNP_RSHARED: begin
                if (is_dirty(init_state)) begin
                    case (next_writer)
                        `RSR_NW_SNOOPED: begin
                            end_state = `RSR_ST_SD; // R08
                        end
                        `RSR_NW_INIT: begin
                            pass_dirty = 1'b1; // R08
                            if (init_store_first && !excl_hit)
                                end_state = `RSR_ST_I;
                            else
                                end_state = `RSR_ST_SC; // R09
                        end
                        default: begin
                            pass_dirty = 1'b1; // R13 R14
                            end_state  = `RSR_ST_SC; // R13
                        end
                    endcase
                end else if (is_valid(init_state)) begin
                    end_state = `RSR_ST_SC; // R07 R09
                end
            end
            // Dirty may only leave when our copy goes Invalid
            `RSR_SNP_RNSD: begin
                if (is_dirty(init_state)) begin
                    if ((next_writer == `RSR_NW_INIT) && !excl_hit) begin
                        end_state  = `RSR_ST_I; // R15
                        pass_dirty = 1'b1; // R15
                    end else begin
                        end_state  = `RSR_ST_SD; // R08 R09
                    end
                end else if (is_valid(init_state)) begin
                    end_state = `RSR_ST_SC; // R07 R09
                end
            end
            `RSR_SNP_RUNIQUE: begin
                end_state  = `RSR_ST_I; // R16
                pass_dirty = is_dirty(init_state); // R16
            end
            default: begin
                supported = 1'b0;
                end_state = init_state;
            end
        endcase
        is_shared = supported && is_valid(end_state); // R06 R16
        data_xfer = supported && is_valid(init_state); // R03 R04 R10 R17 R18
    end

endmodule // rsr_decide

`default_nettype wire

/* File: testbench/rsr_snoop_resp_properties.sv */
`include "rsr_consts.vh"
`default_nettype none
module rsr_snoop_resp_chk (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   acvalid,
    input wire logic                   acready,
    input wire logic [`RSR_SNP_W-1:0]  acsnoop,
    input wire logic                   crvalid,
    input wire logic                   crready,
    input wire logic [`RSR_RESP_W-1:0] crresp,
    input wire logic                   cdvalid,
    input wire logic                   cdready,
    input wire logic                   cdlast,
    input wire logic                   lw_ready,
    input wire logic                   snoop_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_late;
        acvalid && acready |-> ##1 !crvalid ##1 crvalid;
    endproperty
    a_late: assert property (p_late) else $error("response not two cycles after take");
    property p_busy;
        crvalid |-> !acready && snoop_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("new snoop open during response");
    property p_dt;
        $rose(crvalid) |-> crresp[`RSR_RESP_DT] == cdvalid;
    endproperty
    a_dt: assert property (p_dt) else $error("data flag and data channel disagree");
    property p_uniq;
        $rose(crvalid) && $past(acsnoop, 2) == `RSR_SNP_RUNIQUE |-> !crresp[`RSR_RESP_IS];
    endproperty
    a_uniq: assert property (p_uniq) else $error("copy kept on unique snoop");
    property p_once;
        $rose(crvalid) && $past(acsnoop, 2) == `RSR_SNP_RONCE |-> !crresp[`RSR_RESP_PD];
    endproperty
    a_once: assert property (p_once) else $error("dirty passed on read-once");
    property p_pd;
        crvalid && crresp[`RSR_RESP_PD] |-> crresp[`RSR_RESP_DT];
    endproperty
    a_pd: assert property (p_pd) else $error("dirty passed without data");
    property p_stand;
        crvalid && !crready |=> crvalid && $stable(crresp);
    endproperty
    a_stand: assert property (p_stand) else $error("response dropped before taken");
    property p_cdend;
        cdvalid && cdready && cdlast |=> !cdvalid;
    endproperty
    a_cdend: assert property (p_cdend) else $error("data beat after last");
    property p_look;
        $rose(snoop_busy) |-> !lw_ready;
    endproperty
    a_look: assert property (p_look) else $error("local write open in lookup");
endmodule // rsr_snoop_resp_chk
bind rsr_snoop_resp rsr_snoop_resp_chk u_chk (.clk(clk), .rst_n(rst_n), .acvalid(acvalid),
    .acready(acready), .acsnoop(acsnoop), .crvalid(crvalid), .crready(crready),
    .crresp(crresp), .cdvalid(cdvalid), .cdready(cdready), .cdlast(cdlast),
    .lw_ready(lw_ready), .snoop_busy(snoop_busy));
`default_nettype wire

/* File: testbench/rsr_ic_model.sv */
`default_nettype none
module rsr_ic_model (
    input wire logic         clk,
    input wire logic         slow,
    input wire logic         acready,
    output var logic         acvalid,
    output var logic [31:0]  acaddr,
    output var logic [3:0]   acsnoop,
    output var logic         crready,
    output var logic         cdready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        acvalid = 1'b0;
        acaddr = 32'h0;
        acsnoop = 4'h0;
        crready = 1'b1;
        cdready = 1'b1;
    end
    // Always accepts in the end, even a passed dirty line; stalls only in slow mode
    always @(posedge clk) begin
        crready <= slow ? 1'($urandom) : 1'b1;
        cdready <= slow ? 1'($urandom) : 1'b1;
    end
    // Released lines show the inverse so a stale value is never mistaken for a request
    task automatic snoop(input logic [31:0] a, input logic [3:0] op);
        acvalid <= 1'b1;
        acaddr <= a;
        acsnoop <= op;
        do @(posedge clk); while (!acready);
        acvalid <= 1'b0;
        acaddr <= ~a;
        acsnoop <= ~op;
    endtask
endmodule // rsr_ic_model
`default_nettype wire

/* File: testbench/read_snoop_response_tb_top.sv */
`include "rsr_consts.vh"
`default_nettype none
module read_snoop_response_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, lw_valid, excl_valid, init_store_first, slow;
    logic        acvalid, acready, crvalid, crready, cdvalid, cdready, cdlast;
    logic        lw_ready, snoop_busy;
    logic [31:0] acaddr, lw_addr, excl_addr, cddata;
    logic [63:0] lw_data;
    logic [3:0]  acsnoop;
    logic [4:0]  crresp;
    logic [2:0]  lw_state;
    logic [1:0]  next_writer;
    logic [4:0]  rq[$];
    logic [32:0] dq[$];
    int          mismatches, checks, cycles;

    rsr_snoop_resp dut (.clk(clk), .rst_n(rst_n), .acvalid(acvalid), .acready(acready),
        .acaddr(acaddr), .acsnoop(acsnoop), .crvalid(crvalid), .crready(crready),
        .crresp(crresp), .cdvalid(cdvalid), .cdready(cdready), .cddata(cddata),
        .cdlast(cdlast), .lw_valid(lw_valid), .lw_ready(lw_ready), .lw_addr(lw_addr),
        .lw_state(lw_state), .lw_data(lw_data), .excl_valid(excl_valid),
        .excl_addr(excl_addr), .next_writer(next_writer),
        .init_store_first(init_store_first), .snoop_busy(snoop_busy));
    rsr_ic_model ic (.clk(clk), .slow(slow), .acready(acready), .acvalid(acvalid),
        .acaddr(acaddr), .acsnoop(acsnoop), .crready(crready), .cdready(cdready));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            mismatches++;
        end
    endtask

    // Result layout: end state, pass-dirty, is-shared, data-transfer
    function automatic logic [5:0] rsr_exp(input logic [3:0] op, input logic [2:0] s,
        input logic [1:0] nw, input logic isf, input logic ex);
        logic d;
        d = (s == `RSR_ST_UD) || (s == `RSR_ST_SD);
        rsr_exp = {s, 3'h0};
        if (s != `RSR_ST_I)
            case (op)
                `RSR_SNP_RONCE: rsr_exp = {s, 3'h3};
                `RSR_SNP_RCLEAN: rsr_exp = {d ? `RSR_ST_SD : `RSR_ST_SC, 3'h3};
                `RSR_SNP_RSHARED: rsr_exp = !d ? {`RSR_ST_SC, 3'h3} :
                    nw == `RSR_NW_SNOOPED ? {`RSR_ST_SD, 3'h3} :
                    (nw == `RSR_NW_INIT && isf && !ex) ? {`RSR_ST_I, 3'h5} : {`RSR_ST_SC, 3'h7};
                `RSR_SNP_RNSD: rsr_exp = !d ? {`RSR_ST_SC, 3'h3} :
                    (nw == `RSR_NW_INIT && !ex) ? {`RSR_ST_I, 3'h5} : {`RSR_ST_SD, 3'h3};
                `RSR_SNP_RUNIQUE: rsr_exp = {`RSR_ST_I, d, 2'h1};
                default: ;
            endcase
    endfunction

    task automatic note(input logic [5:0] e, input logic [63:0] d);
        rq.push_back({1'b0, e[1], e[2], 1'b0, e[0]});
        if (e[0]) begin
            dq.push_back({1'b0, d[31:0]});
            dq.push_back({1'b1, d[63:32]});
        end
    endtask

    task automatic install(input logic [31:0] a, input logic [2:0] s, input logic [63:0] d,
        input logic ex, input logic [1:0] nw, input logic isf);
        @(posedge clk);
        lw_valid <= 1'b1;
        lw_addr <= a;
        lw_state <= s;
        lw_data <= d;
        excl_valid <= ex;
        excl_addr <= a;
        next_writer <= nw;
        init_store_first <= isf;
        do @(posedge clk); while (!lw_ready);
        lw_valid <= 1'b0;
        lw_data <= ~d;
    endtask

    task automatic snoop_done(input logic [31:0] a, input logic [3:0] op);
        @(posedge clk);
        slow <= 1'($urandom);
        ic.snoop(a, op);
        do @(negedge clk); while (snoop_busy);
    endtask

    always @(posedge clk) begin
        if (crvalid && crready)
            chk("crresp", rq.size() ? 64'(rq.pop_front()) : 'x, 64'(crresp));
        if (cdvalid && cdready)
            chk("cd beat", dq.size() ? 64'(dq.pop_front()) : 'x, {31'h0, cdlast, cddata});
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        logic [31:0] a;
        logic [63:0] d;
        logic [3:0]  op;
        logic [2:0]  st;
        logic [5:0]  e;
        logic [1:0]  nw;
        logic        ex, isf, mis;
        void'($urandom(32'h35cf));
        {rst_n, lw_valid, excl_valid, init_store_first, slow} = 5'h00;
        {lw_addr, excl_addr, lw_data, lw_state, next_writer} = 133'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 360; i++) begin
            op = (i % 6 < 4) ? 4'(i % 6) : (i % 6 == 4 ? `RSR_SNP_RUNIQUE : 4'h5);
            st = 3'((i / 6) % 5);
            a = $urandom;
            d = {$urandom, $urandom};
            nw = 2'($urandom % 3);
            {ex, isf, mis} = 3'($urandom);
            install(a, st, d, ex, nw, isf);
            // A flipped tag bit hits the same entry but must miss
            e = rsr_exp(op, mis ? `RSR_ST_I : st, nw, isf, ex);
            note(e, d);
            snoop_done(a ^ 32'({mis, 7'h00}), op);
            note(rsr_exp(`RSR_SNP_RONCE, mis ? st : e[5:3], nw, isf, ex), d);
            snoop_done(a, `RSR_SNP_RONCE);
        end
        wrap_up();
    end
endmodule // read_snoop_response_tb_top
`default_nettype wire
